// ---- scap_defs.vh ----
// Constants for the synchronous DRAM command and address front end
`ifndef SCAP_DEFS_VH
`define SCAP_DEFS_VH

// ----------------------------------------------------------------------
// Command codes {row strobe, column strobe, write enable}, active low
// ----------------------------------------------------------------------
`define SCAP_CMD_MODE_SET   3'h0
`define SCAP_CMD_REFRESH    3'h1
`define SCAP_CMD_PRECHARGE  3'h2
`define SCAP_CMD_ACTIVATE   3'h3
`define SCAP_CMD_WRITE      3'h4
`define SCAP_CMD_READ       3'h5
`define SCAP_CMD_BURST_STOP 3'h6
`define SCAP_CMD_NOP        3'h7

// ----------------------------------------------------------------------
// Address field positions
// ----------------------------------------------------------------------
`define SCAP_ROW_MSB        12
`define SCAP_COL_MSB        8
`define SCAP_AP_BIT         10

// ----------------------------------------------------------------------
// Mode register selection by bank select during a mode set cycle
// ----------------------------------------------------------------------
`define SCAP_SEL_STD_MODE   2'h0
`define SCAP_SEL_EXT_MODE   2'h2

// ----------------------------------------------------------------------
// Reset values and burst timing
// ----------------------------------------------------------------------
`define SCAP_MODE_RESET     13'h0000
`define SCAP_BURST_BEATS    4'h4

// ----------------------------------------------------------------------
// Power states
// ----------------------------------------------------------------------
`define SCAP_PWR_RUN        2'h0
`define SCAP_PWR_DOWN       2'h1
`define SCAP_PWR_SUSPEND    2'h2
`define SCAP_PWR_SELFREF    2'h3

`endif

// ---- scap_cmd_decode.v ----
// Command decoder: turns chip select and the three strobes into a command
`timescale 1ns/10ps
`include "scap_defs.vh"

module scap_cmd_decode (
   // Command pins
   input  wire       chipSelectN,
   input  wire       rowStrobeN,
   input  wire       colStrobeN,
   input  wire       writeEnableN,
   // Decoded command
   output wire       cmdValid,
   output wire [2:0] cmdCode,
   output wire       isActivate,
   output wire       isAccess,
   output wire       isPrecharge,
   output wire       isModeSet,
   output wire       isRefresh,
   output wire       isBurstStop
);

   wire [2:0] strobes;

   // Match one command code, only while the decoder is enabled
   function isCmd;
      input [2:0] code;
      input [2:0] want;
      input       enabled;
      begin
         isCmd = enabled && (code == want);
      end
   endfunction

   // Chip select high disables the decoder: every cycle is a deselect
   assign strobes     = {rowStrobeN, colStrobeN, writeEnableN};
   assign cmdValid    = ~chipSelectN && (strobes != `SCAP_CMD_NOP);
   assign cmdCode     = chipSelectN ? `SCAP_CMD_NOP : strobes;
   assign isActivate  = isCmd(strobes, `SCAP_CMD_ACTIVATE, ~chipSelectN);
   assign isAccess    = isCmd(strobes, `SCAP_CMD_READ, ~chipSelectN) |
                        isCmd(strobes, `SCAP_CMD_WRITE, ~chipSelectN);
   assign isPrecharge = isCmd(strobes, `SCAP_CMD_PRECHARGE, ~chipSelectN);
   assign isModeSet   = isCmd(strobes, `SCAP_CMD_MODE_SET, ~chipSelectN);
   assign isRefresh   = isCmd(strobes, `SCAP_CMD_REFRESH, ~chipSelectN);
   assign isBurstStop = isCmd(strobes, `SCAP_CMD_BURST_STOP, ~chipSelectN);

endmodule

// ---- scap_bank_track.v ----
// Per-bank open state and open row, one slice per bank
`timescale 1ns/10ps
`include "scap_defs.vh"

module scap_bank_track (
   // Clock and reset
   input  wire        clk,
   input  wire        rst,
   // Updates, all qualified by the caller
   input  wire [3:0]  activateMask,
   input  wire [12:0] activateRow,
   input  wire [3:0]  prechargeMask,
   // State
   output wire [3:0]  bankOpen,
   output wire [51:0] openRows
);

   genvar b;

   // Each bank opens on activate and closes on precharge
   generate
      for (b = 0; b < 4; b = b + 1) begin : bankSlice
         reg        open_reg;
         reg [12:0] row_reg;
         always @(posedge clk) begin
            if (rst) begin
               open_reg <= 1'b0;
               row_reg  <= 13'h0000;
            end else if (activateMask[b]) begin
               open_reg <= 1'b1;
               row_reg  <= activateRow;
            end else if (prechargeMask[b]) begin
               open_reg <= 1'b0;
            end
         end
         assign bankOpen[b]            = open_reg;
         assign openRows[b*13 +: 13]   = row_reg;
      end
   endgenerate

endmodule

// ---- scap_cmd_addr.v ----
// Command, bank and address front end of a four-bank synchronous DRAM
`timescale 1ns/10ps
`include "scap_defs.vh"

module scap_cmd_addr (
   // Clock and reset
   input  wire        clk,
   input  wire        rst,
   // Command pins from the controller
   input  wire        clkGate,
   input  wire        chipSelectN,
   input  wire        rowStrobeN,
   input  wire        colStrobeN,
   input  wire        writeEnableN,
   // Bank and address pins
   input  wire        bank_select_0,
   input  wire        bank_select_1,
   input  wire [12:0] addr,
   // Accepted command
   output reg         cmdTaken,
   output reg  [2:0]  cmdCode,
   output reg  [1:0]  cmdBank,
   output reg  [12:0] rowAddr,
   output reg  [8:0]  colAddr,
   output reg         autoPrecharge,
   // Bank state
   output reg  [3:0]  prechargePulse,
   output wire [3:0]  bankOpen,
   output wire [51:0] openRows,
   // Burst state
   output reg         burstActive,
   output reg         burstWrite,
   output reg  [1:0]  burstBank,
   // Mode registers
   output reg  [12:0] modeReg,
   output reg  [12:0] extModeReg,
   // Power state
   output reg  [1:0]  powerState,
   output wire        clockActive
);

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   wire        decValid;
   wire [2:0]  decCode;
   wire        decActivate;
   wire        decAccess;
   wire        decPrecharge;
   wire        decModeSet;
   wire        decRefresh;
   wire        decBurstStop;
   wire [1:0]  bankSel;
   wire        addr10_auto_precharge;
   wire        running;
   wire        takeCmd;
   wire        burstLast;
   wire [3:0]  cmdPreMask;
   wire [3:0]  apEndMask;
   wire [3:0]  actMask;
   wire        takeActivate;
   wire        takeAccess;
   wire        takePrecharge;
   wire        takeModeSet;
   wire        takeBurstStop;

   reg  [1:0]  power_reg;
   reg  [1:0]  power_next;
   reg  [3:0]  beats_reg;
   reg  [3:0]  beats_next;
   reg         burstAp_reg;
   reg         burstAp_next;
   reg         burstOn_next;
   reg         burstWr_next;
   reg  [1:0]  burstBank_next;

   // One-hot bank mask from a bank number
   function [3:0] bankMask;
      input [1:0] bank;
      begin
         bankMask = 4'h1 << bank;
      end
   endfunction

   // ----------------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------------
   // Pins come from logic on this same clock, so no synchroniser is needed
   // The decoder is pure logic; every capture happens in the flops of this module and of its bank tracker
   scap_cmd_decode uDecode (
      .chipSelectN  (chipSelectN),
      .rowStrobeN   (rowStrobeN),
      .colStrobeN   (colStrobeN),
      .writeEnableN (writeEnableN),
      .cmdValid     (decValid),
      .cmdCode      (decCode),
      .isActivate   (decActivate),
      .isAccess     (decAccess),
      .isPrecharge  (decPrecharge),
      .isModeSet    (decModeSet),
      .isRefresh    (decRefresh),
      .isBurstStop  (decBurstStop)
   );

   assign bankSel               = {bank_select_1, bank_select_0};
   assign addr10_auto_precharge = addr[`SCAP_AP_BIT];

   // The clock counts only in the run state with the gate high
   assign running     = (power_reg == `SCAP_PWR_RUN) && clkGate;
   assign clockActive = running;
   // Commands are taken only on a live edge with the decoder enabled
   assign takeCmd     = running && decValid;

   // ----------------------------------------------------------------------
   // Qualified commands
   // ----------------------------------------------------------------------
   // Each command but refresh is qualified once here, so every consumer sees the same
   // gating; a deselected or gated edge can never leak into one of them
   assign takeActivate  = takeCmd && decActivate;
   assign takeAccess    = takeCmd && decAccess;
   assign takePrecharge = takeCmd && decPrecharge;
   assign takeModeSet   = takeCmd && decModeSet;
   assign takeBurstStop = takeCmd && decBurstStop;

   // ----------------------------------------------------------------------
   // Precharge masks
   // ----------------------------------------------------------------------
   // Explicit precharge: bit 10 high hits every bank, else only the named one.
   // Both sources merge into one mask; the tracker treats them alike
   assign cmdPreMask = takePrecharge ?
                       (addr10_auto_precharge ? 4'hF : bankMask(bankSel)) :
                       4'h0;
   // Auto-precharge closes the burst's bank on its last beat
   assign burstLast  = running && burstActive && (beats_reg == 4'h1);
   assign apEndMask  = (burstLast && burstAp_reg) ? bankMask(burstBank) : 4'h0;
   assign actMask    = takeActivate ? bankMask(bankSel) : 4'h0;

   // Pins never name one bank for activate and precharge in one cycle; only an
   // auto-precharge end can meet an activate, and then the activate wins
   scap_bank_track uBanks (
      .clk           (clk),
      .rst           (rst),
      .activateMask  (actMask),
      .activateRow   (addr),
      .prechargeMask (cmdPreMask | apEndMask),
      .bankOpen      (bankOpen),
      .openRows      (openRows)
   );

   // ----------------------------------------------------------------------
   // Command capture
   // ----------------------------------------------------------------------
   // Fields are latched only on the rising edge that takes a command.
   // cmdTaken is a one-cycle pulse; cmdCode and cmdBank hold until the next command,
   // the row and column fields until the next of their own kind, so the host may read them at leisure
   always @(posedge clk) begin
      if (rst) begin
         cmdTaken       <= 1'b0;
         cmdCode        <= `SCAP_CMD_NOP;
         cmdBank        <= 2'h0;
         rowAddr        <= 13'h0000;
         colAddr        <= 9'h000;
         autoPrecharge  <= 1'b0;
         prechargePulse <= 4'h0;
      end else begin
         cmdTaken       <= takeCmd;
         prechargePulse <= cmdPreMask | apEndMask;
         if (takeCmd) begin
            cmdCode <= decCode;
            cmdBank <= bankSel;
            if (decActivate) begin
               rowAddr <= addr[`SCAP_ROW_MSB:0];
            end
            if (decAccess) begin
               colAddr       <= addr[`SCAP_COL_MSB:0];
               autoPrecharge <= addr10_auto_precharge;
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Mode registers
   // ----------------------------------------------------------------------
   // Bank selects steer the write; other select codes are ignored.
   // Dropping codes 01 and 11 rather than aliasing them means a stray
   // select can never corrupt either register
   always @(posedge clk) begin
      if (rst) begin
         modeReg    <= `SCAP_MODE_RESET;
         extModeReg <= `SCAP_MODE_RESET;
      end else if (takeModeSet) begin
         if (bankSel == `SCAP_SEL_STD_MODE) begin
            modeReg <= addr;
         end else if (bankSel == `SCAP_SEL_EXT_MODE) begin
            extModeReg <= addr;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Burst tracking
   // ----------------------------------------------------------------------
   // A running burst keeps counting on deselected cycles; a new access
   // restarts it, which drops a pending auto-precharge of the old one unless the access lands on that burst's last beat.
   // Counting freezes while the gate is low, so a suspend resumes mid-burst
   always @* begin
      beats_next     = beats_reg;
      burstOn_next   = burstActive;
      burstWr_next   = burstWrite;
      burstBank_next = burstBank;
      burstAp_next   = burstAp_reg;
      if (running) begin
         if (takeAccess) begin
            beats_next     = `SCAP_BURST_BEATS;
            burstOn_next   = 1'b1;
            burstWr_next   = ~writeEnableN;
            burstBank_next = bankSel;
            burstAp_next   = addr10_auto_precharge;
         end else if (takeBurstStop) begin
            beats_next   = 4'h0;
            burstOn_next = 1'b0;
            burstAp_next = 1'b0;
         end else if (burstActive) begin
            beats_next = beats_reg - 4'h1;
            if (burstLast) begin
               burstOn_next = 1'b0;
               burstAp_next = 1'b0;
            end
         end
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         beats_reg   <= 4'h0;
         burstActive <= 1'b0;
         burstWrite  <= 1'b0;
         burstBank   <= 2'h0;
         burstAp_reg <= 1'b0;
      end else begin
         beats_reg   <= beats_next;
         burstActive <= burstOn_next;
         burstWrite  <= burstWr_next;
         burstBank   <= burstBank_next;
         burstAp_reg <= burstAp_next;
      end
   end

   // ----------------------------------------------------------------------
   // Power state
   // ----------------------------------------------------------------------
   // Gate low picks the low-power mode from what the device is doing;
   // gate high on any later edge returns to run.
   // Limitation: a refresh means self-refresh entry only on the very edge
   // where the gate first drops; one a cycle earlier is a plain refresh
   always @* begin
      power_next = power_reg;
      case (power_reg)
         `SCAP_PWR_RUN: begin
            if (!clkGate) begin
               if (decRefresh) begin
                  power_next = `SCAP_PWR_SELFREF;
               end else if (burstActive) begin
                  power_next = `SCAP_PWR_SUSPEND;
               end else begin
                  power_next = `SCAP_PWR_DOWN;
               end
            end
         end
         `SCAP_PWR_DOWN, `SCAP_PWR_SUSPEND, `SCAP_PWR_SELFREF: begin
            if (clkGate) begin
               power_next = `SCAP_PWR_RUN;
            end
         end
         default: begin
            power_next = `SCAP_PWR_RUN;
         end
      endcase
   end

   always @(posedge clk) begin
      if (rst) begin
         power_reg  <= `SCAP_PWR_RUN;
         powerState <= `SCAP_PWR_RUN;
      end else begin
         power_reg  <= power_next;
         powerState <= power_next;
      end
   end

endmodule

// ---- scap_cmd_addr_props.sv ----
// Concurrent checks on the command and address front end
`timescale 1ns/10ps
`include "scap_defs.vh"

module scap_cmd_addr_props (
   // Clock and reset
   input wire        clk,
   input wire        rst,
   // Pins from the controller
   input wire        clkGate,
   input wire        chipSelectN,
   input wire        rowStrobeN,
   input wire        colStrobeN,
   input wire        writeEnableN,
   input wire        bank_select_0,
   input wire        bank_select_1,
   input wire [12:0] addr,
   // Results
   input wire        cmdTaken,
   input wire [2:0]  cmdCode,
   input wire [1:0]  cmdBank,
   input wire [12:0] rowAddr,
   input wire [8:0]  colAddr,
   input wire        autoPrecharge,
   input wire [3:0]  prechargePulse,
   input wire [12:0] modeReg,
   input wire [12:0] extModeReg,
   input wire [1:0]  powerState
);
   // ------------
   // Pin decode
   // ------------
   wire [2:0] cmd  = {rowStrobeN, colStrobeN, writeEnableN};
   wire [1:0] bank = {bank_select_1, bank_select_0};
   wire [8:0] col  = addr[8:0];
   wire       ap   = addr[`SCAP_AP_BIT];
   // A command counts only when the part is awake, gated on and selected
   wire take = !chipSelectN && clkGate && powerState == `SCAP_PWR_RUN && cmd != `SCAP_CMD_NOP;

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // ------------
   // Assertions
   // ------------
   take_pulse_a: assert property (take |=> cmdTaken && cmdCode == $past(cmd))
      else $error("taken command not reported");
   desel_ignore_a: assert property (chipSelectN |=> !cmdTaken)
      else $error("command taken while deselected");
   gate_ignore_a: assert property (!clkGate |=> !cmdTaken)
      else $error("command taken with clock gated");
   low_power_a: assert property (powerState == `SCAP_PWR_RUN && !clkGate |=>
      powerState != `SCAP_PWR_RUN)
      else $error("gate low did not leave run");
   row_take_a: assert property (take && cmd == `SCAP_CMD_ACTIVATE |=>
      rowAddr == $past(addr) && cmdBank == $past(bank))
      else $error("row or bank not captured");
   col_take_a: assert property (take && cmd[2] && !cmd[1] |=>
      colAddr == $past(col) && autoPrecharge == $past(ap))
      else $error("column or flag not captured");
   pre_all_a: assert property (take && cmd == `SCAP_CMD_PRECHARGE && ap |=>
      prechargePulse == 4'hF)
      else $error("precharge all missed a bank");
   pre_one_a: assert property (take && cmd == `SCAP_CMD_PRECHARGE && !ap |=>
      prechargePulse[$past(bank)])
      else $error("named bank not precharged");
   mode_std_a: assert property (take && cmd == `SCAP_CMD_MODE_SET && bank == `SCAP_SEL_STD_MODE |=>
      modeReg == $past(addr))
      else $error("mode register not written");
   mode_ext_a: assert property (take && cmd == `SCAP_CMD_MODE_SET && bank == `SCAP_SEL_EXT_MODE |=>
      extModeReg == $past(addr) && $stable(modeReg))
      else $error("extended mode register not written");

   // Main scenarios reached
   cov_act: cover property (take && cmd == `SCAP_CMD_ACTIVATE);
   cov_pre_all: cover property (take && cmd == `SCAP_CMD_PRECHARGE && ap);
   cov_selfref: cover property (powerState == `SCAP_PWR_SELFREF);
endmodule

bind scap_cmd_addr scap_cmd_addr_props u_props (.clk(clk), .rst(rst), .clkGate(clkGate), .chipSelectN(chipSelectN),
   .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN), .writeEnableN(writeEnableN), .bank_select_0(bank_select_0),
   .bank_select_1(bank_select_1), .addr(addr), .cmdTaken(cmdTaken), .cmdCode(cmdCode), .cmdBank(cmdBank),
   .rowAddr(rowAddr), .colAddr(colAddr), .autoPrecharge(autoPrecharge), .prechargePulse(prechargePulse),
   .modeReg(modeReg), .extModeReg(extModeReg), .powerState(powerState));

// ---- scap_host_model.sv ----
// Host controller model driving command, bank and address pins
`timescale 1ns/10ps

module scap_host_model (
   // Clock
   input  wire       clk,
   // Pins toward the device
   output reg        clkGate,
   output reg        chipSelectN,
   output reg        rowStrobeN,
   output reg        colStrobeN,
   output reg        writeEnableN,
   output reg        bank_select_0,
   output reg        bank_select_1,
   output reg [12:0] addr
);
   // Idle and deselected from time zero
   initial begin
      clkGate = 1'b1;
      chipSelectN = 1'b1;
      {rowStrobeN, colStrobeN, writeEnableN} = 3'h7;
      {bank_select_1, bank_select_0} = 2'h0;
      addr = 13'h0000;
   end

   // One command held over one edge, then deselect; stale lines are inverted so nothing leans on them
   task issue(input g, input csN, input [2:0] code, input [1:0] bank, input [12:0] a);
      begin
         @(posedge clk);
         #2;
         clkGate = g;
         chipSelectN = csN;
         {rowStrobeN, colStrobeN, writeEnableN} = code;
         {bank_select_1, bank_select_0} = bank;
         addr = a;
         @(posedge clk);
         #2;
         chipSelectN = 1'b1;
         {rowStrobeN, colStrobeN, writeEnableN} = ~code;
         {bank_select_1, bank_select_0} = ~bank;
         addr = ~a;
      end
   endtask
endmodule

// ---- tb_sdram_command_address_pins.sv ----
// Self-checking bench for the command and address front end
`timescale 1ns/10ps
`include "scap_defs.vh"

module tb_sdram_command_address_pins;
   // ------------
   // Signals
   // ------------
   reg         clk;
   reg         rst;
   wire        clkGate, chipSelectN, rowStrobeN, colStrobeN, writeEnableN, bank_select_0, bank_select_1;
   wire [12:0] addr, rowAddr, modeReg, extModeReg;
   wire        cmdTaken, autoPrecharge, burstActive, clockActive;
   wire [2:0]  cmdCode;
   wire [1:0]  cmdBank, powerState;
   wire [8:0]  colAddr;
   wire [3:0]  prechargePulse, bankOpen;
   wire [51:0] openRows;
   wire        burstWrite;
   wire [1:0]  burstBank;
   integer     errors, n_compared, i;

   scap_host_model u_host (.clk(clk), .clkGate(clkGate), .chipSelectN(chipSelectN), .rowStrobeN(rowStrobeN),
      .colStrobeN(colStrobeN), .writeEnableN(writeEnableN), .bank_select_0(bank_select_0),
      .bank_select_1(bank_select_1), .addr(addr));

   scap_cmd_addr u_dut (.clk(clk), .rst(rst), .clkGate(clkGate), .chipSelectN(chipSelectN), .rowStrobeN(rowStrobeN),
      .colStrobeN(colStrobeN), .writeEnableN(writeEnableN), .bank_select_0(bank_select_0),
      .bank_select_1(bank_select_1), .addr(addr), .cmdTaken(cmdTaken), .cmdCode(cmdCode), .cmdBank(cmdBank),
      .rowAddr(rowAddr), .colAddr(colAddr), .autoPrecharge(autoPrecharge), .prechargePulse(prechargePulse),
      .bankOpen(bankOpen), .openRows(openRows), .burstActive(burstActive), .burstWrite(burstWrite),
      .burstBank(burstBank),
      .modeReg(modeReg), .extModeReg(extModeReg), .powerState(powerState), .clockActive(clockActive));

   // 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // ------------
   // Compare and close
   // ------------
   task chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
         end
      end
   endtask

   task end_of_test;
      begin
         $display("compared %0d errors %0d", n_compared, errors);
         if (errors == 0 && n_compared > 0) begin
            $display("bench passed");
         end else begin
            $display("bench failed");
         end
         $finish;
      end
   endtask

   // ------------
   // Scenarios
   // ------------
   // Every command code but NOP in turn, a deselected edge between each; mode set to bank 1 writes nothing
   task s_codes;
      begin
         for (i = 0; i < 7; i = i + 1) begin
            u_host.issue(1'b1, 1'b0, i[2:0], 2'h1, 13'h0123);
            chk("cmdTaken", 1, cmdTaken);
            chk("cmdCode", i, cmdCode);
         end
         chk("modeReg", 13'h0000, modeReg);
         chk("extModeReg", 13'h0000, extModeReg);
      end
   endtask

   // Deselected activate must leave everything alone
   task s_deselect;
      begin
         u_host.issue(1'b1, 1'b1, `SCAP_CMD_ACTIVATE, 2'h2, 13'h0ABC);
         chk("cmdTaken", 0, cmdTaken);
         chk("rowAddr", 13'h0123, rowAddr);
      end
   endtask

   task s_activate;
      begin
         u_host.issue(1'b1, 1'b0, `SCAP_CMD_ACTIVATE, 2'h2, 13'h1ABC);
         chk("rowAddr", 13'h1ABC, rowAddr);
         chk("cmdBank", 2'h2, cmdBank);
         chk("bankOpen2", 1, bankOpen[2]);
         chk("openRow2", 13'h1ABC, openRows[38:26]);
      end
   endtask

   // Read with auto-precharge; the burst must finish while deselected
   task s_read_ap;
      begin
         u_host.issue(1'b1, 1'b0, `SCAP_CMD_READ, 2'h1, 13'h1D55);
         chk("colAddr", 9'h155, colAddr);
         chk("autoPrecharge", 1, autoPrecharge);
         chk("burstActive", 1, burstActive);
         chk("burstWrite", 0, burstWrite);
         chk("burstBank", 2'h1, burstBank);
         for (i = 0; i < 8 && bankOpen[1] !== 1'b0; i = i + 1) begin
            @(posedge clk);
            #2;
         end
         chk("closeWait", 1, i < 8);
         chk("prechargePulse", 4'h2, prechargePulse);
         if (i == 8) end_of_test;
      end
   endtask

   task s_precharge;
      begin
         u_host.issue(1'b1, 1'b0, `SCAP_CMD_PRECHARGE, 2'h1, 13'h0400);
         chk("prechargePulse", 4'hF, prechargePulse);
         chk("bankOpen", 4'h0, bankOpen);
         u_host.issue(1'b1, 1'b0, `SCAP_CMD_ACTIVATE, 2'h0, 13'h0005);
         u_host.issue(1'b1, 1'b0, `SCAP_CMD_ACTIVATE, 2'h3, 13'h0006);
         u_host.issue(1'b1, 1'b0, `SCAP_CMD_PRECHARGE, 2'h3, 13'h1BFF);
         chk("prechargePulse", 4'h8, prechargePulse);
         chk("bankOpen", 4'h1, bankOpen);
         chk("openRow0", 13'h0005, openRows[12:0]);
      end
   endtask

   task s_mode;
      begin
         u_host.issue(1'b1, 1'b0, `SCAP_CMD_MODE_SET, `SCAP_SEL_STD_MODE, 13'h0123);
         chk("modeReg", 13'h0123, modeReg);
         u_host.issue(1'b1, 1'b0, `SCAP_CMD_MODE_SET, `SCAP_SEL_EXT_MODE, 13'h1456);
         chk("extModeReg", 13'h1456, extModeReg);
         u_host.issue(1'b1, 1'b0, `SCAP_CMD_MODE_SET, 2'h1, 13'h0777);
         chk("modeReg", 13'h0123, modeReg);
         chk("extModeReg", 13'h1456, extModeReg);
      end
   endtask

   // Gate low: power-down, refused command, self-refresh, suspend
   task s_power;
      begin
         u_host.issue(1'b0, 1'b1, `SCAP_CMD_NOP, 2'h0, 13'h0000);
         chk("powerState", `SCAP_PWR_DOWN, powerState);
         chk("clockActive", 0, clockActive);
         u_host.issue(1'b0, 1'b0, `SCAP_CMD_ACTIVATE, 2'h1, 13'h0011);
         chk("cmdTaken", 0, cmdTaken);
         u_host.issue(1'b1, 1'b1, `SCAP_CMD_NOP, 2'h0, 13'h0000);
         chk("powerState", `SCAP_PWR_RUN, powerState);
         u_host.issue(1'b0, 1'b0, `SCAP_CMD_REFRESH, 2'h0, 13'h0000);
         chk("powerState", `SCAP_PWR_SELFREF, powerState);
         u_host.issue(1'b1, 1'b1, `SCAP_CMD_NOP, 2'h0, 13'h0000);
         u_host.issue(1'b1, 1'b0, `SCAP_CMD_READ, 2'h0, 13'h0000);
         u_host.issue(1'b0, 1'b1, `SCAP_CMD_NOP, 2'h0, 13'h0000);
         chk("powerState", `SCAP_PWR_SUSPEND, powerState);
      end
   endtask

   // Main sequence
   initial begin
      errors = 0;
      n_compared = 0;
      rst = 1'b1;
      repeat (12) @(posedge clk);
      #2;
      rst = 1'b0;
      s_codes;
      s_deselect;
      s_activate;
      s_read_ap;
      s_precharge;
      s_mode;
      s_power;
      end_of_test;
   end
endmodule
